// ### src/cpmc_pkg.sv
/*
 * cpmc_pkg: register offsets, field positions, reset values, mode and
 * state encodings and oscillator timing for the clock and power mode
 * controller.
 * assumes: a 40 MHz block clock; included before every cpmc module.
 */
package cpmc_pkg;

    // ------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_FOC  = 4'h0;  // fast_osc_control
    localparam logic [3:0] REG_SCC  = 4'h1;  // system_clock_control
    localparam logic [3:0] REG_STAT = 4'h2;  // status flags
    localparam logic [3:0] REG_WAKE = 4'h3;  // port_a_wake_enable

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FOC_EN_BIT     = 0;
    localparam int FOC_STABLE_BIT = 1;
    localparam int FOC_FREQ_LSB   = 2;
    localparam int SCC_SLOW_BIT   = 0;
    localparam int SCC_FAST_BIT   = 1;
    localparam int SCC_SEL_LSB    = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FOC_RST  = 8'h00;
    localparam logic [7:0] SCC_RST  = 8'he0;
    localparam logic [7:0] WAKE_RST = 8'h00;
    localparam logic [2:0] SEL_SLOW = 3'h7;

    // ------------------------------------------------------------
    // fast oscillator stabilisation time
    // ------------------------------------------------------------
    localparam int STAB_TIME_NS  = 16000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_CW       = 10;
    localparam logic [STAB_CW-1:0] STAB_LAST = STAB_CW'(STAB_CYCLES - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FREQ_2MHZ = 2'h0,
        FREQ_4MHZ = 2'h1,
        FREQ_8MHZ = 2'h2
    } cpmc_freq_t;

    // code is {fast_keep_in_halt, slow_keep_in_halt}
    typedef enum logic [1:0] {
        LP_SLEEP     = 2'h0,
        LP_IDLE_SLOW = 2'h1,
        LP_IDLE_FAST = 2'h2,
        LP_IDLE_BOTH = 2'h3
    } cpmc_lp_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_LOW  = 2'h1,
        ST_WAKE = 2'h3
    } cpmc_state_t;

    // frequency code to applied frequency; code 3 aliases 2 MHz
    function automatic cpmc_freq_t cpmc_decode_freq(input logic [1:0] code);
        cpmc_decode_freq = (code == 2'h1) ? FREQ_4MHZ :
                           (code == 2'h2) ? FREQ_8MHZ : FREQ_2MHZ;
    endfunction : cpmc_decode_freq

endpackage : cpmc_pkg

// ### src/cpmc_osc_stab.sv
/*
 * cpmc_osc_stab: counts the fast oscillator settling time and raises
 * the stable flag once it has elapsed.
 * assumes: osc_on is the registered oscillator enable of the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cpmc_osc_stab
    import cpmc_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic ce,
    // oscillator control
    input  wire logic osc_on,
    input  wire logic restart,
    // status
    output logic      stable_q
);

    logic [STAB_CW-1:0] cnt_q;

    // settle counter, cleared while off or on restart
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q    <= '0;
            stable_q <= 1'b0;
        end else if (ce) begin
            if (!osc_on || restart) begin
                cnt_q    <= '0;
                stable_q <= 1'b0;
            end else if (cnt_q == STAB_LAST) begin
                stable_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule : cpmc_osc_stab

`default_nettype wire

// ### src/cpmc_ctrl.sv
/*
 * cpmc_ctrl: fast oscillator control, system clock selection and
 * halt / low-power / wake-up sequencing of a small microcontroller.
 * assumes: all inputs synchronous to clock; halt and clear-watchdog
 * arrive as one-cycle pulses from the cpu; watchdog counter is outside.
 */
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cpmc_ctrl
    import cpmc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ce,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    // cpu events
    input  wire logic        halt_exec,
    input  wire logic        clr_wdt_exec,
    input  wire logic        stack_full,
    output logic             cpu_run_q,
    output logic             resume_next_q,
    output logic             irq_respond_q,
    output logic             pc_sp_reset_q,
    // watchdog
    input  wire logic        wdt_enable,
    input  wire logic        wdt_overflow,
    output logic             wdt_clear_q,
    output logic             wdt_run_q,
    output logic             wdt_reset_req_q,
    // wake sources
    input  wire logic [7:0]  porta_in,
    input  wire logic [7:0]  irq_req,
    input  wire logic [7:0]  irq_enable,
    // oscillators and system clock
    input  wire logic        slow_osc_stable,
    output logic             fast_osc_on_q,
    output logic             sub_clk_on_q,
    output cpmc_freq_t       fast_freq_q,
    output logic             sys_clk_on_q,
    output logic      [2:0]  sys_clk_sel_q
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic              foc_en_q;
    logic [1:0]        foc_freq_q;
    logic [2:0]        scc_sel_q;
    logic              fast_keep_q;
    logic              slow_keep_q;
    logic [7:0]        wake_en_q;
    logic              pdf_q;
    logic              to_q;
    cpmc_state_t       state_q;
    cpmc_state_t       state_d;
    cpmc_lp_t          mode_q;
    cpmc_lp_t          mode_d;
    logic [7:0]        porta_q;
    logic [7:0]        irq_pre_q;
    logic              cause_wdt_q;
    logic              cause_irq_q;
    logic              irq_serv_q;
    logic              fast_stable;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_foc  = reg_wr && (reg_addr == REG_FOC);
    wire wr_scc  = reg_wr && (reg_addr == REG_SCC);
    wire wr_wake = reg_wr && (reg_addr == REG_WAKE);

    // read selection; unmapped offsets read zero
    wire [7:0] rd_foc  = {4'h0, foc_freq_q, fast_stable, foc_en_q};
    wire [7:0] rd_scc  = {scc_sel_q, 3'h0, fast_keep_q, slow_keep_q};
    wire [7:0] rd_stat = {3'h0, cpu_run_q, mode_q, to_q, pdf_q};
    wire [7:0] rd_mux  = (reg_addr == REG_FOC)  ? rd_foc  :
                         (reg_addr == REG_SCC)  ? rd_scc  :
                         (reg_addr == REG_STAT) ? rd_stat :
                         (reg_addr == REG_WAKE) ? wake_en_q : 8'h00;

    // ------------------------------------------------------------
    // events and wake sources
    // ------------------------------------------------------------
    wire run_st    = (state_q == ST_RUN);
    wire low_st    = (state_q == ST_LOW);
    wire halt_take = halt_exec && run_st;
    // writing the enable bit as 1 restarts the settle count
    wire restart   = wr_foc && reg_wdata[FOC_EN_BIT];

    // falling edge on an enabled port a pin
    wire [7:0] pin_fall = porta_q & ~porta_in & wake_en_q;
    wire       pin_wake = |pin_fall;
    // only requests that were not pending at entry may wake
    wire [7:0] irq_new  = irq_req & ~irq_pre_q;
    wire       irq_wake = |irq_new;
    wire       irq_ok   = |(irq_new & irq_enable) && !stack_full;
    wire       wake_any = pin_wake || irq_wake || wdt_overflow;

    // clock source that the cpu will run from is ready
    wire sel_slow  = (scc_sel_q == SEL_SLOW);
    wire cur_slow  = (sys_clk_sel_q == SEL_SLOW);
    wire sel_go    = sel_slow ? slow_osc_stable : fast_stable;
    wire clk_ready = cur_slow ? slow_osc_stable : fast_stable;

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (halt_take) begin
                    state_d = ST_LOW;
                end
            end
            ST_LOW: begin
                if (wake_any) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (clk_ready) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // low-power mode taken from the keep bits at halt
    assign mode_d = halt_take ? cpmc_lp_t'({fast_keep_q, slow_keep_q}) : mode_q;

    // ------------------------------------------------------------
    // clock gating per mode
    // ------------------------------------------------------------
    wire awake_d  = (state_d != ST_LOW);
    wire lp_sys   = (mode_d == LP_IDLE_BOTH) ||
                    ((mode_d == LP_IDLE_SLOW) && cur_slow) ||
                    ((mode_d == LP_IDLE_FAST) && !cur_slow);
    wire sys_on_d = (state_d == ST_RUN) || (!awake_d && lp_sys);
    wire fast_d   = foc_en_q && (awake_d || mode_d[1]);
    wire sub_d    = awake_d || mode_d[0];

    // new divider and source only once the target oscillator is stable
    wire [2:0] sel_d  = (run_st && sel_go) ? scc_sel_q : sys_clk_sel_q;
    wire [1:0] freq_d = fast_stable ? cpmc_decode_freq(foc_freq_q) : fast_freq_q;

    // ------------------------------------------------------------
    // fast oscillator settling
    // ------------------------------------------------------------
    cpmc_osc_stab u_stab (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .osc_on   (fast_osc_on_q),
        .restart  (restart),
        .stable_q (fast_stable)
    );

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // these change only by writes, so low-power entry keeps them
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            foc_en_q    <= FOC_RST[FOC_EN_BIT];
            foc_freq_q  <= FOC_RST[FOC_FREQ_LSB +: 2];
            scc_sel_q   <= SCC_RST[SCC_SEL_LSB +: 3];
            fast_keep_q <= SCC_RST[SCC_FAST_BIT];
            slow_keep_q <= SCC_RST[SCC_SLOW_BIT];
            wake_en_q   <= WAKE_RST;
        end else if (ce) begin
            if (wr_foc) begin
                foc_en_q   <= reg_wdata[FOC_EN_BIT];
                foc_freq_q <= reg_wdata[FOC_FREQ_LSB +: 2];
            end
            if (wr_scc) begin
                scc_sel_q   <= reg_wdata[SCC_SEL_LSB +: 3];
                fast_keep_q <= reg_wdata[SCC_FAST_BIT];
                slow_keep_q <= reg_wdata[SCC_SLOW_BIT];
            end
            if (wr_wake) begin
                wake_en_q <= reg_wdata;
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (ce) begin
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // status flags: a set wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pdf_q <= 1'b0;
            to_q  <= 1'b0;
        end else if (ce) begin
            if (halt_take) begin
                pdf_q <= 1'b1;
            end else if (clr_wdt_exec) begin
                pdf_q <= 1'b0;
            end
            if (wdt_overflow) begin
                to_q <= 1'b1;
            end else if (halt_take) begin
                to_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer state and wake bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q     <= ST_RUN;
            mode_q      <= LP_SLEEP;
            porta_q     <= 8'h00;
            irq_pre_q   <= 8'h00;
            cause_wdt_q <= 1'b0;
            cause_irq_q <= 1'b0;
            irq_serv_q  <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            mode_q  <= mode_d;
            porta_q <= porta_in;
            if (halt_take) begin
                irq_pre_q <= irq_req;
            end
            if (low_st && wake_any) begin
                cause_wdt_q <= wdt_overflow;
                cause_irq_q <= irq_wake;
                irq_serv_q  <= irq_ok;
            end
        end
    end

    // ------------------------------------------------------------
    // clock and cpu outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpu_run_q     <= 1'b0;
            sys_clk_on_q  <= 1'b0;
            fast_osc_on_q <= 1'b0;
            sub_clk_on_q  <= 1'b0;
            sys_clk_sel_q <= SEL_SLOW;
            fast_freq_q   <= FREQ_2MHZ;
        end else if (ce) begin
            cpu_run_q     <= (state_d == ST_RUN);
            sys_clk_on_q  <= sys_on_d;
            fast_osc_on_q <= fast_d;
            sub_clk_on_q  <= sub_d;
            sys_clk_sel_q <= sel_d;
            fast_freq_q   <= cpmc_freq_t'(freq_d);
        end
    end

    // ------------------------------------------------------------
    // one-cycle pulses to cpu and watchdog, and the registered watchdog run level
    // ------------------------------------------------------------
    wire wake_done = (state_q == ST_WAKE) && clk_ready;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            resume_next_q   <= 1'b0;
            irq_respond_q   <= 1'b0;
            pc_sp_reset_q   <= 1'b0;
            wdt_clear_q     <= 1'b0;
            wdt_run_q       <= 1'b0;
            wdt_reset_req_q <= 1'b0;
        end else if (ce) begin
            pc_sp_reset_q   <= wake_done && cause_wdt_q;
            irq_respond_q   <= wake_done && !cause_wdt_q && cause_irq_q && irq_serv_q;
            resume_next_q   <= wake_done && !cause_wdt_q && !(cause_irq_q && irq_serv_q);
            wdt_clear_q     <= halt_take || clr_wdt_exec;
            wdt_run_q       <= wdt_enable;
            wdt_reset_req_q <= wdt_overflow && !low_st;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    halt_flags_a: assert property (ce && halt_take && !wdt_overflow |=> pdf_q && !to_q)
        else $error("halt did not set power-down and clear time-out");
    halt_mode_a: assert property (ce && halt_take |=>
        low_st && (mode_q == cpmc_lp_t'({$past(fast_keep_q), $past(slow_keep_q)})))
        else $error("halt chose wrong low-power mode");
    sleep_clocks_a: assert property (low_st && mode_q == LP_SLEEP |->
        !sys_clk_on_q && !cpu_run_q && !fast_osc_on_q)
        else $error("sleep left a clock running");
    idle_slow_a: assert property (low_st && mode_q == LP_IDLE_SLOW && $stable(state_q)
        |-> !fast_osc_on_q && sub_clk_on_q)
        else $error("idle_slow_only_mode clocks wrong");
    idle_both_a: assert property (low_st && mode_q == LP_IDLE_BOTH && $stable(state_q)
        |-> sub_clk_on_q && sys_clk_on_q && !cpu_run_q)
        else $error("idle_both_clocks_mode clocks wrong");
    idle_fast_a: assert property (low_st && mode_q == LP_IDLE_FAST && $stable(state_q)
        |-> !sub_clk_on_q && fast_osc_on_q == foc_en_q)
        else $error("idle_fast_only_mode clocks wrong");
    stable_drop_a: assert property (ce && restart |=> !fast_stable)
        else $error("stable flag did not drop on enable");
    halt_wdt_a: assert property (ce && halt_take |=> wdt_clear_q)
        else $error("halt did not clear watchdog");
    pin_wake_a: assert property (ce && low_st && pin_wake |=> state_q == ST_WAKE)
        else $error("pin edge did not wake");
    pending_irq_a: assert property (ce && low_st && !pin_wake && !wdt_overflow &&
        irq_req == irq_pre_q |=> low_st)
        else $error("pending interrupt caused wake");
    freq_apply_a: assert property (ce && !fast_stable |=> fast_freq_q == $past(fast_freq_q))
        else $error("frequency changed while unstable");
    slow_sel_a: assert property (ce && run_st && sel_slow && !slow_osc_stable
        |=> sys_clk_sel_q == $past(sys_clk_sel_q))
        else $error("slow switch before slow oscillator stable");

endmodule : cpmc_ctrl

`default_nettype wire

// ### verif/cpmc_ctrl_tb_top.sv
/* cpmc_ctrl_tb_top: self-checking bench for the clock and power mode controller.
 * assumes: cpmc_pkg and cpmc_ctrl compiled first; 40 MHz clock; ce high except for one freeze check. */
`timescale 1ns/10ps
`default_nettype none
module cpmc_ctrl_tb_top
    import cpmc_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic       clock = 0, resetn = 0, ce = 1, reg_wr = 0, reg_rd = 0, halt_exec = 0;
    logic       clr_wdt_exec = 0, stack_full = 0, wdt_enable = 0, wdt_overflow = 0;
    logic       slow_osc_stable = 1, cpu_run_q, resume_next_q, irq_respond_q, pc_sp_reset_q;
    logic       wdt_clear_q, wdt_run_q, wdt_reset_req_q, fast_osc_on_q, sub_clk_on_q;
    logic       sys_clk_on_q;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, porta_in = 8'hff, irq_req = 0, irq_enable = 0, reg_rdata_q, d;
    logic [2:0] sys_clk_sel_q;
    cpmc_freq_t fast_freq_q;
    int         errors = 0, n_compared = 0, i, k, n;
    logic [1:0] prev = 2'h0;

    cpmc_ctrl cpmc_ctrl_i (.clock(clock), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .stack_full(stack_full),
        .cpu_run_q(cpu_run_q), .resume_next_q(resume_next_q), .irq_respond_q(irq_respond_q),
        .pc_sp_reset_q(pc_sp_reset_q), .wdt_enable(wdt_enable), .wdt_overflow(wdt_overflow),
        .wdt_clear_q(wdt_clear_q), .wdt_run_q(wdt_run_q), .wdt_reset_req_q(wdt_reset_req_q),
        .porta_in(porta_in), .irq_req(irq_req), .irq_enable(irq_enable),
        .slow_osc_stable(slow_osc_stable), .fast_osc_on_q(fast_osc_on_q),
        .sub_clk_on_q(sub_clk_on_q), .fast_freq_q(fast_freq_q), .sys_clk_on_q(sys_clk_on_q),
        .sys_clk_sel_q(sys_clk_sel_q));

    // ----------------------------------------------------------------
    // clock, helpers and bus tasks
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clock = ~clock;
    end

    function automatic logic [7:0] exp_f(input logic [1:0] c);
        exp_f = (c == 2'h1) ? 8'h01 : (c == 2'h2) ? 8'h02 : 8'h00;
    endfunction : exp_f

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clock); reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clock); reg_rd <= 1'b0;
        @(negedge clock); v = reg_rdata_q;
    endtask : rd

    // one-cycle pulse on halt_exec, clr_wdt_exec and wdt_overflow, looked at in the answer cycle
    task automatic pulse(input logic h, input logic c, input logic o);
        @(posedge clock); halt_exec <= h; clr_wdt_exec <= c; wdt_overflow <= o;
        @(posedge clock); halt_exec <= 1'b0; clr_wdt_exec <= 1'b0; wdt_overflow <= 1'b0;
        @(negedge clock);
    endtask : pulse

    task final_report;
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // watchdog against a hung wait
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        final_report;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hcab4));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock); @(negedge clock);
        chk(sys_clk_sel_q, 8'h07);
        chk(cpu_run_q, 8'h01);
        rd(REG_FOC, d); chk(d, 8'h00);
        rd(REG_SCC, d); chk(d, 8'he0);
        rd(REG_STAT, d); chk(d, 8'h10);
        rd(4'hf, d); chk(d, 8'h00);
        // every frequency code, junk in the read-only and unused bits
        for (i = 0; i < 4; i++) begin
            k = $urandom;
            wr(REG_FOC, {k[7:4], i[1:0], k[1], 1'b1});
            @(negedge clock); chk(fast_freq_q, exp_f(prev));
            rd(REG_FOC, d); chk(d, {4'h0, i[1:0], 2'b01});
            for (n = 0; n < 400 && d[1] !== 1'b1; n++) rd(REG_FOC, d);
            chk(d, {4'h0, i[1:0], 2'b11});
            chk(fast_freq_q, exp_f(i[1:0]));
            prev = i[1:0];
        end
        // every fast divider, reserved select bits and watchdog run follow
        for (i = 0; i < 7; i++) begin
            k = $urandom;
            @(posedge clock); wdt_enable <= k[8];
            wr(REG_SCC, {i[2:0], k[4:0]});
            rd(REG_SCC, d); chk(d, {i[2:0], 3'h0, k[1:0]});
            chk(sys_clk_sel_q, i[7:0]);
            chk(wdt_run_q, wdt_enable);
        end
        @(posedge clock); slow_osc_stable <= 1'b0;
        wr(REG_SCC, 8'he0);
        repeat (6) @(negedge clock);
        chk(sys_clk_sel_q, 8'h06);
        @(posedge clock); slow_osc_stable <= 1'b1;
        repeat (3) @(negedge clock);
        chk(sys_clk_sel_q, 8'h07);
        pulse(1'b0, 1'b0, 1'b1); chk(wdt_reset_req_q, 8'h01);
        // a low clock enable freezes the registers
        @(posedge clock); ce <= 1'b0;
        wr(REG_WAKE, 8'h5a);
        @(posedge clock); ce <= 1'b1;
        rd(REG_WAKE, d); chk(d, 8'h00);
        // halt into each low-power mode, waking by a port a pin, an interrupt, an interrupt with the stack full and a watchdog overflow
        for (i = 0; i < 4; i++) begin
            k = $urandom_range(7);
            wr(REG_WAKE, 8'h01 << k);
            rd(REG_WAKE, d); chk(d, 8'h01 << k);
            wr(REG_SCC, {6'h0, i[1:0]});
            @(posedge clock); irq_req <= {7'h0, i == 0};
            pulse(1'b1, 1'b0, 1'b0);
            chk(cpu_run_q, 8'h00);
            chk(wdt_clear_q, 8'h01);
            chk(fast_osc_on_q, i[1]);
            chk(sub_clk_on_q, i[0]);
            chk(sys_clk_on_q, i[1]);
            chk(sys_clk_sel_q, 8'h00);
            rd(REG_STAT, d); chk(d, {4'h0, i[1:0], 2'b01});
            case (i)
                0: begin
                    repeat (20) @(negedge clock);
                    chk(cpu_run_q, 8'h00);
                    @(posedge clock); porta_in <= ~(8'h01 << k);
                end
                1: begin
                    @(posedge clock); irq_req <= 8'h02; irq_enable <= 8'h02;
                end
                2: begin
                    @(posedge clock); irq_req <= 8'h04; irq_enable <= 8'h04; stack_full <= 1;
                end
                default: pulse(1'b0, 1'b0, 1'b1);
            endcase
            for (n = 0; n < 1000 && cpu_run_q !== 1'b1; n++) @(negedge clock);
            chk(cpu_run_q, 8'h01);
            chk({pc_sp_reset_q, irq_respond_q, resume_next_q},
                (i == 3) ? 8'h04 : (i == 1) ? 8'h02 : 8'h01);
            @(posedge clock);
            porta_in <= 8'hff; irq_req <= 8'h00; irq_enable <= 8'h00; stack_full <= 1'b0;
            rd(REG_STAT, d); chk(d[1:0], {i == 3, 1'b1});
            pulse(1'b0, 1'b1, 1'b0);
            rd(REG_STAT, d); chk(d[0], 8'h00);
        end
        final_report;
    end
endmodule : cpmc_ctrl_tb_top
`default_nettype wire
